// file: hw/sltpg_cfg.svh
// Constants for the serial link test pattern generator
`ifndef SLTPG_CFG_SVH
`define SLTPG_CFG_SVH
`define SLTPG_LANES 4
`define SLTPG_SEL_W 4
`define SLTPG_SEL_NONE 4'h0
`define SLTPG_SEL_STP 4'h1
`define SLTPG_SEL_D215 4'h2
`define SLTPG_SEL_K285 4'h3
`define SLTPG_SEL_RILA 4'h4
`define SLTPG_SEL_RPAT 4'h5
`define SLTPG_D215 8'hB5
`define SLTPG_K285 8'hBC
`define SLTPG_K_IDLE 8'hBC
`define SLTPG_RPAT_LEN 4'hC
`define SLTPG_ILA_LEN 8'h10
`endif

// file: hw/sltpg_lane.sv
// One lane's octet selector for the test pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "sltpg_cfg.svh"
module sltpg_lane #(
	parameter logic [7:0] LANE_IDX = 8'h00
) (
	input wire logic [`SLTPG_SEL_W-1:0] sel,
	input wire logic lane_on,
	input wire sltpg_pkg::sltpg_link_e link_st,
	input wire logic stp_frame,
	input wire logic [7:0] rpat_octet,
	input wire logic [7:0] ila_octet,
	input wire logic ila_k,
	input wire logic [7:0] sample,
	output sltpg_pkg::sltpg_char_s chr
);
	// Per-lane pattern octets
	wire logic [7:0] stp_octet = stp_frame ? ~LANE_IDX : LANE_IDX; // RULE_01
	wire logic in_cgs = (link_st == sltpg_pkg::SLTPG_CGS);
	wire logic in_ila = (link_st == sltpg_pkg::SLTPG_ILA);
	wire logic [7:0] link_octet = in_cgs ? `SLTPG_K_IDLE : (in_ila ? ila_octet : sample);
	wire logic link_k = in_cgs | (in_ila & ila_k);
	// Mode selection; unpowered lanes send nothing
	always_comb begin
		chr = '{octet: 8'h00, is_k: 1'b0};
		if (lane_on) begin // RULE_10
			unique case (sel)
				`SLTPG_SEL_STP: chr = '{octet: stp_octet, is_k: 1'b0}; // RULE_01
				`SLTPG_SEL_D215: chr = '{octet: `SLTPG_D215, is_k: 1'b0}; // RULE_02
				`SLTPG_SEL_K285: chr = '{octet: `SLTPG_K285, is_k: 1'b1}; // RULE_03
				`SLTPG_SEL_RPAT: chr = '{octet: rpat_octet, is_k: 1'b0}; // RULE_06
				default: chr = '{octet: link_octet, is_k: link_k}; // RULE_11
			endcase
		end
	end
endmodule
`default_nettype wire

// file: hw/sltpg_pkg.sv
// Types shared by the serial link test pattern generator
`default_nettype none
package sltpg_pkg;
	typedef struct packed {
		logic [7:0] octet;
		logic is_k;
	} sltpg_char_s;
	typedef enum logic [1:0] {
		SLTPG_CGS,
		SLTPG_ILA,
		SLTPG_DATA
	} sltpg_link_e;
endpackage
`default_nettype wire

// file: hw/sltpg_top.sv
// Serial link test pattern generator, top level
`timescale 1ns/1ps
`default_nettype none
`include "sltpg_cfg.svh"
// How it works
// (RULE_01) Short transport mode sends lane index in frame zero and its complement in frame one.
// (RULE_02) Alternating-bits mode sends D21.5 data characters without break on every lane.
// (RULE_03) Comma mode sends K28.5 control characters without break on every lane.
// (RULE_04) Repeated alignment mode restarts the alignment sequence forever and never sends data.
// (RULE_05) A sync request in repeated alignment mode restarts code group sync, then alignment.
// (RULE_06) Modified RPAT mode repeats a twelve-octet sequence on each lane.
// (RULE_07) RPAT octets go to the encoder in the fixed order BE D7 23 47 6B 8F B3 14 5E FB 35 59.
// (RULE_08) The pattern is chosen by the test_pattern_select input.
// (RULE_09) Software changes test_pattern_select only while the link is disabled.
// (RULE_10) Only lanes powered by lane_config_mode carry any pattern.
// (RULE_11) With no test mode, sample data passes unchanged through the link.
module sltpg_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic link_en,
	input wire logic sync_req,
	input wire logic [`SLTPG_SEL_W-1:0] test_pattern_select,
	input wire logic [1:0] lane_config_mode,
	input wire logic [8*`SLTPG_LANES-1:0] samples_a,
	input wire logic [8*`SLTPG_LANES-1:0] samples_b,
	output sltpg_pkg::sltpg_char_s [`SLTPG_LANES-1:0] link_a_q,
	output sltpg_pkg::sltpg_char_s [`SLTPG_LANES-1:0] link_b_q,
	output logic [1:0] link_state_q
);
	// ****************************************
	// Link sequencing
	// ****************************************
	sltpg_pkg::sltpg_link_e st_q, st_d;
	logic [7:0] ila_cnt_q;
	logic [3:0] rpat_q;
	logic stp_q;
	wire logic rila = (test_pattern_select == `SLTPG_SEL_RILA);
	wire logic ila_last = (ila_cnt_q == `SLTPG_ILA_LEN - 8'h01);
	wire logic rpat_last = (rpat_q == `SLTPG_RPAT_LEN - 4'h1);
	// Next link state: sync request always forces code group sync
	always_comb begin
		st_d = st_q;
		if (!link_en || sync_req) begin
			st_d = sltpg_pkg::SLTPG_CGS; // RULE_05
		end else begin
			unique case (st_q)
				sltpg_pkg::SLTPG_CGS: st_d = sltpg_pkg::SLTPG_ILA;
				sltpg_pkg::SLTPG_ILA: st_d = (ila_last && !rila) ? sltpg_pkg::SLTPG_DATA
					: sltpg_pkg::SLTPG_ILA; // RULE_04
				sltpg_pkg::SLTPG_DATA: st_d = sltpg_pkg::SLTPG_DATA;
				default: st_d = sltpg_pkg::SLTPG_CGS;
			endcase
		end
	end
	// State and counters; ILA counter wraps so alignment repeats
	// Counter holds at zero outside alignment so every pass opens with its start marker
	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= sltpg_pkg::SLTPG_CGS;
			ila_cnt_q <= 8'h00;
			rpat_q <= 4'h0;
			stp_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ila_cnt_q <= (st_q != sltpg_pkg::SLTPG_ILA || ila_last) ? 8'h00
				: ila_cnt_q + 8'h01; // RULE_04
			rpat_q <= rpat_last ? 4'h0 : rpat_q + 4'h1; // RULE_06
			stp_q <= ~stp_q; // RULE_01
		end
	end
	// ****************************************
	// Pattern tables
	// ****************************************
	logic [7:0] rpat_octet;
	// RPAT octets in encoder order; lane octet is one frame here
	always_comb begin
		unique case (rpat_q)
			4'h0: rpat_octet = 8'hBE; // RULE_07
			4'h1: rpat_octet = 8'hD7;
			4'h2: rpat_octet = 8'h23;
			4'h3: rpat_octet = 8'h47;
			4'h4: rpat_octet = 8'h6B;
			4'h5: rpat_octet = 8'h8F;
			4'h6: rpat_octet = 8'hB3;
			4'h7: rpat_octet = 8'h14;
			4'h8: rpat_octet = 8'h5E;
			4'h9: rpat_octet = 8'hFB;
			4'hA: rpat_octet = 8'h35;
			4'hB: rpat_octet = 8'h59;
			default: rpat_octet = 8'h00;
		endcase
	end
	// Simplified ILA content: K28.0 start marker, counter body, K28.3 end marker
	wire logic ila_first = (ila_cnt_q == 8'h00);
	wire logic [7:0] ila_octet = ila_first ? 8'h1C : (ila_last ? 8'h7C : ila_cnt_q);
	wire logic ila_k = ila_first | ila_last;
	// ****************************************
	// Lanes
	// ****************************************
	// Lanes powered: mode 0 one, 1 two, 2 and 3 four; pattern sits on lowest lanes
	wire logic [3:0] lanes_on = (lane_config_mode == 2'h0) ? 4'h1
		: ((lane_config_mode == 2'h1) ? 4'h3 : 4'hF); // RULE_10
	sltpg_pkg::sltpg_char_s [`SLTPG_LANES-1:0] a_d;
	sltpg_pkg::sltpg_char_s [`SLTPG_LANES-1:0] b_d;
	genvar g;
	generate
		for (g = 0; g < `SLTPG_LANES; g++) begin : g_lane
			sltpg_lane #(.LANE_IDX(8'(g))) u_a (
				.sel(test_pattern_select), // RULE_08
				.lane_on(lanes_on[g]),
				.link_st(st_q),
				.stp_frame(stp_q),
				.rpat_octet(rpat_octet),
				.ila_octet(ila_octet),
				.ila_k(ila_k),
				.sample(samples_a[8*g +: 8]),
				.chr(a_d[g])
			);
			sltpg_lane #(.LANE_IDX(8'(g))) u_b (
				.sel(test_pattern_select),
				.lane_on(lanes_on[g]),
				.link_st(st_q),
				.stp_frame(stp_q),
				.rpat_octet(rpat_octet),
				.ila_octet(ila_octet),
				.ila_k(ila_k),
				.sample(samples_b[8*g +: 8]),
				.chr(b_d[g])
			);
		end
	endgenerate
	// Registered outputs; disabled link sends zeros
	always_ff @(posedge clk) begin
		if (!resetn) begin
			link_a_q <= '0;
			link_b_q <= '0;
			link_state_q <= 2'h0;
		end else begin
			link_a_q <= link_en ? a_d : '0;
			link_b_q <= link_en ? b_d : '0;
			link_state_q <= st_q;
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	a_rila_no_data: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
		rila |-> st_q != sltpg_pkg::SLTPG_DATA || $past(!rila))
		else $error("data phase entered in repeated alignment mode");
	a_sync_restart: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
		sync_req |=> st_q == sltpg_pkg::SLTPG_CGS)
		else $error("sync request did not restart code group sync");
	a_rpat_start: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
		link_en && test_pattern_select == `SLTPG_SEL_RPAT && rpat_q == 4'h0
		|=> link_a_q[0].octet == 8'hBE && !link_a_q[0].is_k)
		else $error("rpat order wrong");
	a_rpat_wrap: assert property (@(posedge clk) disable iff (!resetn) // RULE_06
		rpat_q == 4'hB |=> rpat_q == 4'h0)
		else $error("rpat length not twelve");
	a_stp_toggle: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
		stp_q |=> !stp_q ##1 stp_q)
		else $error("short transport frame not alternating");
	a_k285_out: assert property (@(posedge clk) disable iff (!resetn) // RULE_03
		link_en && test_pattern_select == `SLTPG_SEL_K285 |=> link_a_q[0].octet == 8'hBC
		&& link_a_q[0].is_k)
		else $error("comma mode not sending K28.5");
	a_d215_out: assert property (@(posedge clk) disable iff (!resetn) // RULE_02
		link_en && test_pattern_select == `SLTPG_SEL_D215 |=> link_b_q[0].octet == 8'hB5)
		else $error("alternating mode not sending D21.5");
	a_lane_off: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
		lane_config_mode == 2'h0 |=> link_a_q[1] == '0)
		else $error("unpowered lane carries pattern");
	a_data_pass: assert property (@(posedge clk) disable iff (!resetn) // RULE_11
		link_en && test_pattern_select == `SLTPG_SEL_NONE && st_q == sltpg_pkg::SLTPG_DATA
		&& lanes_on[0] |=> link_a_q[0].octet == $past(samples_a[7:0]))
		else $error("sample data altered");
	// Further checks; most look at what leaves the block, a_sync_resume at the link state, a_rila_repeat at the link state and ILA counter, none at the tables
	a_stp_frame0: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
		link_en && test_pattern_select == `SLTPG_SEL_STP && !stp_q && lane_config_mode[1]
		|=> link_b_q[3].octet == 8'h03 && !link_b_q[3].is_k)
		else $error("short transport frame zero wrong on lane three");
	a_stp_frame1: assert property (@(posedge clk) disable iff (!resetn) // RULE_01
		link_en && test_pattern_select == `SLTPG_SEL_STP && stp_q
		|=> link_a_q[0].octet == 8'hFF)
		else $error("short transport frame one wrong on lane zero");
	a_rpat_mid: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
		link_en && test_pattern_select == `SLTPG_SEL_RPAT && rpat_q == 4'h7
		|=> link_b_q[0].octet == 8'h14)
		else $error("rpat octet seven wrong");
	a_rpat_end: assert property (@(posedge clk) disable iff (!resetn) // RULE_07
		link_en && test_pattern_select == `SLTPG_SEL_RPAT && rpat_q == 4'hB
		|=> link_a_q[0].octet == 8'h59)
		else $error("rpat last octet wrong");
	a_cgs_comma: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
		link_en && st_q == sltpg_pkg::SLTPG_CGS && test_pattern_select == `SLTPG_SEL_RILA
		|=> link_a_q[0].octet == 8'hBC && link_a_q[0].is_k)
		else $error("code group sync not sending commas");
	a_sync_resume: assert property (@(posedge clk) disable iff (!resetn) // RULE_05
		link_en && !sync_req && st_q == sltpg_pkg::SLTPG_CGS
		|=> st_q == sltpg_pkg::SLTPG_ILA)
		else $error("alignment did not follow code group sync");
	a_rila_repeat: assert property (@(posedge clk) disable iff (!resetn) // RULE_04
		link_en && !sync_req && rila && st_q == sltpg_pkg::SLTPG_ILA && ila_last
		|=> st_q == sltpg_pkg::SLTPG_ILA && ila_cnt_q == 8'h00)
		else $error("alignment sequence did not restart");
	a_lanes_two: assert property (@(posedge clk) disable iff (!resetn) // RULE_10
		lane_config_mode == 2'h1
		|=> link_b_q[2] == '0 && link_b_q[3] == '0)
		else $error("upper lanes active in two-lane mode");
	// Main scenarios that the bench is expected to reach
	c_rila_loop: cover property (@(posedge clk) disable iff (!resetn)
		rila && ila_last ##1 st_q == sltpg_pkg::SLTPG_ILA);
	c_data_phase: cover property (@(posedge clk) disable iff (!resetn)
		st_q == sltpg_pkg::SLTPG_DATA);
	c_rpat_wrap: cover property (@(posedge clk) disable iff (!resetn)
		test_pattern_select == `SLTPG_SEL_RPAT && rpat_last);
	c_sync_restart: cover property (@(posedge clk) disable iff (!resetn)
		rila && sync_req ##1 st_q == sltpg_pkg::SLTPG_CGS);
	c_stp_frame: cover property (@(posedge clk) disable iff (!resetn)
		link_en && test_pattern_select == `SLTPG_SEL_STP && stp_q);
endmodule
`default_nettype wire

// file: tb/sltpg_rx_model.sv
// Receiver model that raises a sync request on command
`timescale 1ns/1ps
`default_nettype none
module sltpg_rx_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic resync,
	input wire sltpg_pkg::sltpg_char_s [3:0] lanes,
	output logic sync_req
);
	logic [3:0] hold_q;
	logic comma;
	// Release only after the hold ran out and commas are arriving again
	assign comma = lanes[0].is_k && lanes[0].octet == 8'hBC;
	always_ff @(negedge clk) begin
		if (!resetn) begin
			hold_q <= 4'h0;
			sync_req <= 1'b0;
		end else begin
			hold_q <= resync ? 4'h8 : (hold_q != 4'h0 ? hold_q - 4'h1 : 4'h0);
			sync_req <= resync || hold_q != 4'h0 || (sync_req && !comma);
		end
	end
endmodule
`default_nettype wire

// file: tb/sltpg_top_test.sv
// Self-checking bench for the test pattern generator
`timescale 1ns/1ps
`default_nettype none
`include "sltpg_cfg.svh"
module sltpg_top_test;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic link_en = 1'b0;
	logic resync = 1'b0;
	logic sync_req;
	logic [3:0] sel = 4'h0;
	logic [1:0] mode = 2'h0;
	logic [31:0] samples_a = 32'hA1B2C3D4;
	logic [31:0] samples_b = 32'h5E6F7081;
	sltpg_pkg::sltpg_char_s [3:0] la;
	sltpg_pkg::sltpg_char_s [3:0] lb;
	logic [1:0] st;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	sltpg_top sltpg_top_i (.clk(clk), .resetn(resetn), .link_en(link_en), .sync_req(sync_req),
		.test_pattern_select(sel), .lane_config_mode(mode), .samples_a(samples_a),
		.samples_b(samples_b), .link_a_q(la), .link_b_q(lb), .link_state_q(st));
	sltpg_rx_model sltpg_rx_model_i (.clk(clk), .resetn(resetn), .resync(resync), .lanes(la),
		.sync_req(sync_req));
	// ****************************************
	// Helpers
	// ****************************************
	always #12.5 clk = ~clk;
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end
	task chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Selection only moves while the link is off
	task start(input logic [3:0] s, input logic [1:0] m);
		@(negedge clk) link_en = 1'b0;
		@(negedge clk) sel = s;
		mode = m;
		@(negedge clk) link_en = 1'b1;
		repeat (24) @(negedge clk);
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_data;
		for (int g = 0; g < 4; g++) begin
			chk("data_a", la[g], {samples_a[8*g+:8], 1'b0});
			chk("data_b", lb[g], {samples_b[8*g+:8], 1'b0});
		end
	endtask
	task t_stp;
		logic [7:0] f0;
		f0 = la[0].octet;
		chk("stp_base", {8'h0, f0 == 8'h00 || f0 == 8'hFF}, 9'h001);
		for (int g = 0; g < 4; g++) begin
			chk("stp_a", la[g], {f0 ^ 8'(g), 1'b0});
			chk("stp_b", lb[g], {f0 ^ 8'(g), 1'b0});
		end
		@(negedge clk);
		chk("stp_next", la[3], {~f0 ^ 8'h03, 1'b0});
	endtask
	// Unpowered lanes must stay at zero whatever the pattern
	task t_fixed(input logic [8:0] exp, input int n);
		for (int g = 0; g < 4; g++) begin
			chk("fix_a", la[g], g < n ? exp : 9'h000);
			chk("fix_b", lb[g], g < n ? exp : 9'h000);
		end
	endtask
	task t_rpat;
		logic [7:0] seq [12];
		int i;
		seq = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F, 8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
		i = 0;
		while (la[0].octet !== 8'hBE && i < 12) begin
			@(negedge clk);
			i++;
		end
		for (i = 0; i < 24; i++) begin
			chk("rpat", lb[3], {seq[i % 12], 1'b0});
			@(negedge clk);
		end
	endtask
	task t_rila;
		int n;
		n = 0;
		for (int i = 0; i < 40; i++) begin
			chk("rila_st", {8'h0, st == 2'h2}, 9'h000);
			if (la[0] === {8'h1C, 1'b1}) n++;
			@(negedge clk);
		end
		chk("rila_rep", {8'h0, n >= 2}, 9'h001);
		resync <= 1'b1;
		@(negedge clk) resync <= 1'b0;
		repeat (4) @(negedge clk);
		chk("rila_cgs", {7'h0, st}, 9'h000);
		repeat (30) @(negedge clk);
		chk("rila_back", {7'h0, st}, 9'h001);
	endtask
	initial begin
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		start(`SLTPG_SEL_NONE, 2'h2);
		t_data();
		start(`SLTPG_SEL_STP, 2'h3);
		t_stp();
		start(`SLTPG_SEL_D215, 2'h3);
		t_fixed({8'hB5, 1'b0}, 4);
		start(`SLTPG_SEL_K285, 2'h1);
		t_fixed({8'hBC, 1'b1}, 2);
		start(`SLTPG_SEL_D215, 2'h0);
		t_fixed({8'hB5, 1'b0}, 1);
		start(`SLTPG_SEL_RPAT, 2'h2);
		t_rpat();
		start(`SLTPG_SEL_RILA, 2'h2);
		t_rila();
		summarize();
	end
endmodule
`default_nettype wire
